// >>> rtl/dmacc_top.sv
// eight-channel dma channel control, addressing and transfer engine with apb register access
//
// Design decisions made here: the register addresses and the APB interface to the registers.
`timescale 1ns/1ps
`default_nettype none
module dmacc_top
    import dmacc_pkg::*;
(
    // clock and reset
    input wire logic pclk,
    input wire logic presetn,
    // apb slave
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [ADDR_W-1:0] paddr,
    input wire logic [31:0] pwdata,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,
    // peripheral requests and indirect offset
    input wire logic [127:0] peripheral_request_lines,
    input wire logic [15:0] periph_ram_offset,
    // dma ram port
    output logic [15:0] ram_addr,
    output logic ram_rd,
    output logic ram_wr,
    output logic [15:0] ram_wdata,
    input wire logic [15:0] ram_rdata,
    // peripheral data bus
    output logic [15:0] periph_addr,
    output logic periph_rd,
    output logic periph_wr,
    output logic [15:0] periph_wdata,
    input wire logic [15:0] periph_rdata,
    // transfer status and interrupts
    output logic byte_xfer,
    output logic [CH_W-1:0] xfer_channel,
    output logic [NUM_CH-1:0] dma_irq
);

    // per-channel software registers
    logic [15:0] ctrl_ff [NUM_CH];
    logic [NUM_CH-1:0] force_ff;
    logic [6:0] req_sel_ff [NUM_CH];
    logic [15:0] pri_base_ff [NUM_CH];
    logic [15:0] sec_base_ff [NUM_CH];
    logic [15:0] pad_ff [NUM_CH];
    logic [9:0] blk_len_ff [NUM_CH];
    // per-channel running state
    logic [15:0] cur_addr_ff [NUM_CH];
    logic [9:0] done_ff [NUM_CH];
    logic [NUM_CH-1:0] pp_sel_ff;
    logic [NUM_CH-1:0] req_pend_ff;
    logic [NUM_CH-1:0] req_prev_ff;
    // engine
    dmacc_eng_t eng_ff;
    logic [CH_W-1:0] ch_ff;
    logic [15:0] per_wdata_ff;
    logic [3:0] last_ch_ff;
    logic [31:0] prdata_ff;
    logic [NUM_CH-1:0] irq_ff;
    logic [15:0] ram_addr_ff;
    logic [15:0] periph_addr_ff;
    logic ram_rd_ff;
    logic ram_wr_ff;
    logic periph_rd_ff;
    logic periph_wr_ff;
    logic [15:0] wdata_ff;
    logic byte_ff;

    // apb decode
    logic wr_acc;
    logic rd_setup;
    logic hit;
    logic ch_hit;
    logic [CH_W-1:0] acc_ch;
    logic [4:0] acc_reg;
    logic [31:0] rd_val;

    // engine combinational
    logic [NUM_CH-1:0] ready_ch;
    logic grant_any;
    logic [CH_W-1:0] grant_ch;
    logic [NUM_CH-1:0] sel_req;
    logic [NUM_CH-1:0] sw_start;
    logic [NUM_CH-1:0] hw_off;
    logic elem_done;
    logic blk_end;
    logic half_pt;
    logic [15:0] cur_ctrl;

    function automatic logic is_ch_reg(input logic [ADDR_W-1:0] a);
        logic [4:0] r;
        r = a[CH_SHIFT-1:0];
        is_ch_reg = (a[ADDR_W-1:CH_SHIFT+CH_W] == '0) &&
                    (r == REG_CTRL || r == REG_REQ || r == REG_PRI_BASE ||
                     r == REG_SEC_BASE || r == REG_PAD || r == REG_BLK_LEN);
    endfunction : is_ch_reg

    function automatic logic [15:0] base_of(input logic pp, input logic [15:0] a, input logic [15:0] b);
        base_of = pp ? b : a;
    endfunction : base_of

    assign acc_ch = paddr[CH_SHIFT+CH_W-1:CH_SHIFT];
    assign acc_reg = paddr[CH_SHIFT-1:0];
    assign ch_hit = is_ch_reg(paddr);
    assign hit = ch_hit || paddr == REG_COLL_STAT || paddr == REG_CHAN_STAT;
    assign wr_acc = psel && penable && pwrite && ch_hit;
    assign rd_setup = psel && !penable && !pwrite;

    // zero wait state slave, error on unmapped address
    assign pready = 1'b1;
    assign pslverr = psel && penable && !hit;
    assign prdata = prdata_ff;

    // register read mux; unimplemented bits read zero
    always_comb
    begin
        rd_val = 32'h0000_0000;
        if (ch_hit)
        begin
            case (acc_reg)
                REG_CTRL: rd_val = {16'h0000, ctrl_ff[acc_ch] & CTRL_MASK};
                REG_REQ: rd_val = {16'h0000, force_ff[acc_ch], 8'h00, req_sel_ff[acc_ch]};
                REG_PRI_BASE: rd_val = {16'h0000, pri_base_ff[acc_ch]};
                REG_SEC_BASE: rd_val = {16'h0000, sec_base_ff[acc_ch]};
                REG_PAD: rd_val = {16'h0000, pad_ff[acc_ch]};
                REG_BLK_LEN: rd_val = {22'h00_0000, blk_len_ff[acc_ch]};
                default: rd_val = 32'h0000_0000;
            endcase
        end
        else if (paddr == REG_CHAN_STAT)
        begin
            rd_val = {20'h0_0000, last_ch_ff, pp_sel_ff};
        end
        else
        begin
            // collision flags are never raised: one engine serialises all ram and peripheral writes
            rd_val = 32'h0000_0000;
        end
    end

    // read data captured in the setup phase so it stands through the access phase
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
            prdata_ff <= 32'h0000_0000;
        else if (rd_setup)
            prdata_ff <= rd_val;
    end

    // request routing, software start detection and hardware stop
    always_comb
    begin
        for (int i = 0; i < NUM_CH; i++)
        begin
            sel_req[i] = peripheral_request_lines[req_sel_ff[i]];
            sw_start[i] = wr_acc && acc_ch == CH_W'(i) && acc_reg == REG_CTRL &&
                          pwdata[CTRL_ON_BIT] && !ctrl_ff[i][CTRL_ON_BIT];
            ready_ch[i] = ctrl_ff[i][CTRL_ON_BIT] && (force_ff[i] || req_pend_ff[i]);
            hw_off[i] = 1'b0;
        end
        cur_ctrl = ctrl_ff[ch_ff];
        elem_done = eng_ff == ENG_WRITE;
        blk_end = elem_done && done_ff[ch_ff] == blk_len_ff[ch_ff];
        half_pt = elem_done && done_ff[ch_ff] == (blk_len_ff[ch_ff] >> 1);
        // one-shot stops after its block; one-shot ping-pong after the secondary block
        if (blk_end && cur_ctrl[CTRL_MODE_LSB+MODE_ONESHOT_BIT] &&
            (!cur_ctrl[CTRL_MODE_LSB+MODE_PINGPONG_BIT] || pp_sel_ff[ch_ff]))
            hw_off[ch_ff] = 1'b1;
    end

    // fixed priority, lowest channel first
    always_comb
    begin
        grant_any = 1'b0;
        grant_ch = '0;
        for (int i = NUM_CH - 1; i >= 0; i--)
        begin
            if (ready_ch[i])
            begin
                grant_any = 1'b1;
                grant_ch = CH_W'(i);
            end
        end
    end

    // software registers; a hardware stop on the same edge as a software write wins the on bit
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            for (int i = 0; i < NUM_CH; i++)
            begin
                ctrl_ff[i] <= REG_RESET;
                req_sel_ff[i] <= 7'h00;
                pri_base_ff[i] <= REG_RESET;
                sec_base_ff[i] <= REG_RESET;
                pad_ff[i] <= REG_RESET;
                blk_len_ff[i] <= 10'h000;
            end
        end
        else
        begin
            if (wr_acc)
            begin
                case (acc_reg)
                    REG_CTRL: ctrl_ff[acc_ch] <= pwdata[15:0] & CTRL_MASK;
                    REG_REQ: req_sel_ff[acc_ch] <= pwdata[6:0];
                    REG_PRI_BASE: pri_base_ff[acc_ch] <= pwdata[15:0];
                    REG_SEC_BASE: sec_base_ff[acc_ch] <= pwdata[15:0];
                    REG_PAD: pad_ff[acc_ch] <= pwdata[15:0];
                    REG_BLK_LEN: blk_len_ff[acc_ch] <= pwdata[9:0];
                    default: ;
                endcase
            end
            for (int i = 0; i < NUM_CH; i++)
            begin
                if (hw_off[i])
                    ctrl_ff[i][CTRL_ON_BIT] <= 1'b0;
            end
        end
    end

    // force: set only by software, cleared only when its transfer ends; the set wins
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
            force_ff <= '0;
        else
        begin
            for (int i = 0; i < NUM_CH; i++)
            begin
                if (wr_acc && acc_ch == CH_W'(i) && acc_reg == REG_REQ && pwdata[REQ_FORCE_BIT])
                    force_ff[i] <= 1'b1;
                else if (elem_done && ch_ff == CH_W'(i))
                    force_ff[i] <= 1'b0;
            end
        end
    end

    // request pending: a rising edge on the selected line; a new edge beats the grant clear
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            req_prev_ff <= '0;
            req_pend_ff <= '0;
        end
        else
        begin
            req_prev_ff <= sel_req;
            for (int i = 0; i < NUM_CH; i++)
            begin
                if (sel_req[i] && !req_prev_ff[i] && ctrl_ff[i][CTRL_ON_BIT])
                    req_pend_ff[i] <= 1'b1;
                else if ((eng_ff == ENG_IDLE && grant_any && grant_ch == CH_W'(i)) ||
                         !ctrl_ff[i][CTRL_ON_BIT])
                    req_pend_ff[i] <= 1'b0;
            end
        end
    end

    // per-channel address, element count and ping-pong side
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            for (int i = 0; i < NUM_CH; i++)
            begin
                cur_addr_ff[i] <= REG_RESET;
                done_ff[i] <= 10'h000;
            end
            pp_sel_ff <= '0;
        end
        else
        begin
            for (int i = 0; i < NUM_CH; i++)
            begin
                if (sw_start[i])
                begin
                    cur_addr_ff[i] <= pri_base_ff[i];
                    done_ff[i] <= 10'h000;
                    pp_sel_ff[i] <= 1'b0;
                end
                else if (elem_done && ch_ff == CH_W'(i))
                begin
                    if (blk_end)
                    begin
                        done_ff[i] <= 10'h000;
                        if (ctrl_ff[i][CTRL_MODE_LSB+MODE_PINGPONG_BIT])
                        begin
                            pp_sel_ff[i] <= !pp_sel_ff[i];
                            cur_addr_ff[i] <= base_of(!pp_sel_ff[i], pri_base_ff[i], sec_base_ff[i]);
                        end
                        else
                            cur_addr_ff[i] <= pri_base_ff[i];
                    end
                    else
                    begin
                        done_ff[i] <= done_ff[i] + 10'h001;
                        if (ctrl_ff[i][CTRL_ADDRK_LSB +: 2] == AM_POSTINC)
                            cur_addr_ff[i] <= cur_addr_ff[i] +
                                (ctrl_ff[i][CTRL_SIZE_BIT] ? STEP_BYTE : STEP_WORD);
                    end
                end
            end
        end
    end

    // transfer engine: grant, read one element, write it
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            eng_ff <= ENG_IDLE;
            ch_ff <= '0;
            per_wdata_ff <= 16'h0000;
        end
        else
        begin
            case (eng_ff)
                ENG_IDLE:
                begin
                    if (grant_any)
                    begin
                        ch_ff <= grant_ch;
                        eng_ff <= ENG_READ;
                    end
                end
                ENG_READ:
                begin
                    // registered so peripheral data stands with its strobe; null data for the dummy write
                    per_wdata_ff <= cur_ctrl[CTRL_DIR_BIT] ? ram_rdata : 16'h0000;
                    eng_ff <= ENG_WRITE;
                end
                ENG_WRITE: eng_ff <= ENG_IDLE;
                default: eng_ff <= ENG_IDLE;
            endcase
        end
    end

    // bus strobes and addresses, registered one cycle ahead of their phase
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            ram_addr_ff <= 16'h0000;
            periph_addr_ff <= 16'h0000;
            ram_rd_ff <= 1'b0;
            ram_wr_ff <= 1'b0;
            periph_rd_ff <= 1'b0;
            periph_wr_ff <= 1'b0;
            wdata_ff <= 16'h0000;
            byte_ff <= 1'b0;
        end
        else
        begin
            ram_rd_ff <= 1'b0;
            ram_wr_ff <= 1'b0;
            periph_rd_ff <= 1'b0;
            periph_wr_ff <= 1'b0;
            if (eng_ff == ENG_IDLE && grant_any)
            begin
                ram_addr_ff <= (ctrl_ff[grant_ch][CTRL_ADDRK_LSB +: 2] == AM_PERIPH) ?
                    (base_of(pp_sel_ff[grant_ch], pri_base_ff[grant_ch], sec_base_ff[grant_ch]) |
                     periph_ram_offset) :
                    cur_addr_ff[grant_ch];
                periph_addr_ff <= pad_ff[grant_ch];
                byte_ff <= ctrl_ff[grant_ch][CTRL_SIZE_BIT];
                ram_rd_ff <= ctrl_ff[grant_ch][CTRL_DIR_BIT];
                periph_rd_ff <= !ctrl_ff[grant_ch][CTRL_DIR_BIT];
            end
            else if (eng_ff == ENG_READ)
            begin
                ram_wr_ff <= !cur_ctrl[CTRL_DIR_BIT];
                // null write rides along with the ram write; with direction set it is ignored
                periph_wr_ff <= cur_ctrl[CTRL_DIR_BIT] || cur_ctrl[CTRL_DUMMY_BIT];
                wdata_ff <= cur_ctrl[CTRL_DIR_BIT] ? ram_rdata : periph_rdata;
            end
        end
    end

    // interrupt pulse per channel, last-active channel status
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            irq_ff <= '0;
            last_ch_ff <= LAST_NONE;
        end
        else
        begin
            irq_ff <= '0;
            if (elem_done)
            begin
                last_ch_ff <= {1'b0, ch_ff};
                irq_ff[ch_ff] <= cur_ctrl[CTRL_HALF_BIT] ? half_pt : blk_end;
            end
        end
    end

    assign ram_addr = ram_addr_ff;
    assign ram_rd = ram_rd_ff;
    assign ram_wr = ram_wr_ff;
    assign ram_wdata = wdata_ff;
    assign periph_addr = periph_addr_ff;
    assign periph_rd = periph_rd_ff;
    assign periph_wr = periph_wr_ff;
    // null data to the peripheral when it is not the write target
    assign periph_wdata = per_wdata_ff;
    assign byte_xfer = byte_ff;
    assign xfer_channel = ch_ff;
    assign dma_irq = irq_ff;

endmodule : dmacc_top
`default_nettype wire

// >>> rtl/dmacc_pkg.sv
// constants, encodings and register map of the eight-channel dma channel control block
package dmacc_pkg;
    localparam int NUM_CH = 8;
    localparam int CH_W = 3;
    localparam int ADDR_W = 12;
    // per-channel register window: channel n starts at n << CH_SHIFT
    localparam int CH_SHIFT = 5;
    localparam logic [4:0] REG_CTRL = 5'h00;
    localparam logic [4:0] REG_REQ = 5'h04;
    localparam logic [4:0] REG_PRI_BASE = 5'h08;
    localparam logic [4:0] REG_SEC_BASE = 5'h0C;
    localparam logic [4:0] REG_PAD = 5'h10;
    localparam logic [4:0] REG_BLK_LEN = 5'h14;
    localparam logic [ADDR_W-1:0] REG_COLL_STAT = 12'h100;
    localparam logic [ADDR_W-1:0] REG_CHAN_STAT = 12'h104;
    // control register fields
    localparam int CTRL_ON_BIT = 15;
    localparam int CTRL_SIZE_BIT = 14;
    localparam int CTRL_DIR_BIT = 13;
    localparam int CTRL_HALF_BIT = 12;
    localparam int CTRL_DUMMY_BIT = 11;
    localparam int CTRL_ADDRK_LSB = 4;
    localparam int CTRL_MODE_LSB = 0;
    localparam logic [15:0] CTRL_MASK = 16'hF833;
    // request select fields
    localparam int REQ_FORCE_BIT = 15;
    localparam logic [15:0] REQ_SEL_MASK = 16'h007F;
    localparam logic [15:0] LEN_MASK = 16'h03FF;
    localparam logic [15:0] REG_RESET = 16'h0000;
    localparam logic [3:0] LAST_NONE = 4'hF;
    // addressing kinds
    localparam logic [1:0] AM_POSTINC = 2'h0;
    localparam logic [1:0] AM_NOINC = 2'h1;
    localparam logic [1:0] AM_PERIPH = 2'h2;
    // block modes: bit 0 one-shot, bit 1 ping-pong
    localparam int MODE_ONESHOT_BIT = 0;
    localparam int MODE_PINGPONG_BIT = 1;
    localparam logic [15:0] STEP_BYTE = 16'h0001;
    localparam logic [15:0] STEP_WORD = 16'h0002;

    typedef enum logic [1:0] {ENG_IDLE, ENG_READ, ENG_WRITE} dmacc_eng_t;
endpackage : dmacc_pkg

// >>> tb/dmacc_periph_model.sv
// peripheral data registers and dma ram read data facing the channel engine
`timescale 1ns/1ps
`default_nettype none
module dmacc_periph_model (
    // clock
    input wire logic pclk,
    // ram side
    input wire logic [15:0] ram_addr,
    input wire logic ram_rd,
    output logic [15:0] ram_rdata,
    // peripheral side
    input wire logic [15:0] periph_addr,
    input wire logic periph_rd,
    output logic [15:0] periph_rdata
);
    logic [15:0] junk_ff = 16'h0000;
    // data churns outside a read strobe so a late sample shows up as wrong data
    always_ff @(posedge pclk)
    begin
        junk_ff <= junk_ff + 16'h1357;
    end
    assign ram_rdata = ram_rd ? (ram_addr ^ 16'hC33C) : junk_ff;
    assign periph_rdata = periph_rd ? (periph_addr ^ 16'h5AA5) : ~junk_ff;
endmodule : dmacc_periph_model
`default_nettype wire

// >>> tb/dmacc_top_checker.sv
// port assertions for the dma channel control block
`timescale 1ns/1ps
`default_nettype none
module dmacc_top_checker
    import dmacc_pkg::*;
(
    // clock and reset
    input wire logic pclk,
    input wire logic presetn,
    // apb
    input wire logic psel,
    input wire logic penable,
    input wire logic pready,
    input wire logic pslverr,
    // data paths
    input wire logic ram_rd,
    input wire logic ram_wr,
    input wire logic [15:0] ram_rdata,
    input wire logic [15:0] ram_wdata,
    input wire logic periph_rd,
    input wire logic periph_wr,
    input wire logic [15:0] periph_rdata,
    input wire logic [15:0] periph_wdata,
    // status
    input wire logic byte_xfer,
    input wire logic [CH_W-1:0] xfer_channel,
    input wire logic [NUM_CH-1:0] dma_irq
);
    default clocking cb @(posedge pclk); endclocking
    default disable iff (!presetn);
    logic any_rd;
    logic any_wr;
    assign any_rd = ram_rd | periph_rd;
    assign any_wr = ram_wr | periph_wr;
    a_one_source: assert property (ram_rd |-> !periph_rd) else $error("two read strobes");
    a_rd_then_wr: assert property (any_rd |=> any_wr && !any_rd) else $error("read not followed by write");
    a_wr_has_rd: assert property (any_wr |-> $past(any_rd)) else $error("write without read");
    a_elem_gap: assert property (any_rd |=> !any_rd [*2]) else $error("elements too close");
    a_null_zero: assert property (ram_wr && periph_wr |-> periph_wdata == 16'h0000) else $error("null data");
    a_ram_to_per: assert property (periph_wr && !ram_wr |-> periph_wdata == $past(ram_rdata))
        else $error("peripheral write data");
    a_per_to_ram: assert property (ram_wr |-> ram_wdata == $past(periph_rdata))
        else $error("ram write data");
    a_irq_owner: assert property (dma_irq != 8'h00 |-> $past(any_wr) && dma_irq == (8'h01 << xfer_channel))
        else $error("irq channel");
    a_err_access: assert property (pslverr |-> psel && penable) else $error("error outside access");
    a_zero_wait: assert property (psel && penable |-> pready) else $error("apb not ready");
endmodule : dmacc_top_checker
bind dmacc_top dmacc_top_checker u_chk (.pclk, .presetn, .psel, .penable, .pready, .pslverr, .ram_rd, .ram_wr,
    .ram_rdata, .ram_wdata, .periph_rd, .periph_wr, .periph_rdata, .periph_wdata, .byte_xfer, .xfer_channel,
    .dma_irq);
`default_nettype wire

// >>> tb/dmacc_top_bench.sv
// self-checking bench for the dma channel control block
`timescale 1ns/1ps
`default_nettype none
module dmacc_top_bench;
    import dmacc_pkg::*;
    logic pclk = 1'b0;
    logic presetn = 1'b0;
    logic psel = 1'b0;
    logic penable = 1'b0;
    logic pwrite = 1'b0;
    logic [ADDR_W-1:0] paddr = '0;
    logic [31:0] pwdata = '0;
    logic [127:0] req_lines = '0;
    logic [15:0] ind_off = '0;
    logic [31:0] prdata;
    logic pready, pslverr, ram_rd, ram_wr, periph_rd, periph_wr, byte_xfer;
    logic [15:0] ram_addr, ram_wdata, ram_rdata, periph_addr, periph_wdata, periph_rdata;
    logic [2:0] xfer_channel;
    logic [7:0] dma_irq;
    logic [32:0] q_rd[$];
    logic [32:0] q_ram[$];
    logic [32:0] q_per[$];
    logic [7:0] q_irq[$];
    int err_total = 0;
    int num_checks = 0;
    int cyc = 0;
    always #12.5 pclk = ~pclk;
    dmacc_top dut (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite),
        .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
        .peripheral_request_lines(req_lines), .periph_ram_offset(ind_off), .ram_addr(ram_addr),
        .ram_rd(ram_rd), .ram_wr(ram_wr), .ram_wdata(ram_wdata), .ram_rdata(ram_rdata),
        .periph_addr(periph_addr), .periph_rd(periph_rd), .periph_wr(periph_wr), .periph_wdata(periph_wdata),
        .periph_rdata(periph_rdata), .byte_xfer(byte_xfer), .xfer_channel(xfer_channel), .dma_irq(dma_irq));
    dmacc_periph_model u_far (.pclk(pclk), .ram_addr(ram_addr), .ram_rd(ram_rd), .ram_rdata(ram_rdata),
        .periph_addr(periph_addr), .periph_rd(periph_rd), .periph_rdata(periph_rdata));
    task automatic stop_test();
        $display("checks %0d mismatches %0d", num_checks, err_total);
        if (err_total == 0 && num_checks > 0)
            $display("Finished cleanly");
        else
            $display("Finished with errors");
        $finish;
    endtask : stop_test
    task automatic check(input string what, input logic [32:0] exp, input logic [32:0] got);
        num_checks++;
        if (exp !== got)
        begin
            err_total++;
            $display("CHECK FAILED %s expected %h seen %h", what, exp, got);
        end
    endtask : check
    // one apb transfer; request held until pready is seen high
    task automatic apb(input logic wr, input logic [ADDR_W-1:0] a, input logic [31:0] d);
        psel <= 1'b1;
        pwrite <= wr;
        paddr <= a;
        pwdata <= d;
        @(posedge pclk);
        penable <= 1'b1;
        @(posedge pclk);
        while (pready !== 1'b1) @(posedge pclk);
        psel <= 1'b0;
        penable <= 1'b0;
        // one idle edge so a following call never sets psel in the same time step
        @(posedge pclk);
    endtask : apb
    task automatic rd(input logic [ADDR_W-1:0] a, input logic [32:0] e);
        q_rd.push_back(e);
        apb(1'b0, a, 32'h0);
    endtask : rd
    function automatic logic [ADDR_W-1:0] ra(input logic [2:0] ch, input logic [4:0] r);
        return ADDR_W'({ch, r});
    endfunction : ra
    task automatic cfg(input logic [2:0] ch, input logic [15:0] c, s, a, b, p, n);
        apb(1'b1, ra(ch, REG_REQ), {16'h0, s});
        apb(1'b1, ra(ch, REG_PRI_BASE), {16'h0, a});
        apb(1'b1, ra(ch, REG_SEC_BASE), {16'h0, b});
        apb(1'b1, ra(ch, REG_PAD), {16'h0, p});
        apb(1'b1, ra(ch, REG_BLK_LEN), {16'h0, n});
        apb(1'b1, ra(ch, REG_CTRL), {16'h0, c});
    endtask : cfg
    task automatic settle();
        int n;
        n = 0;
        while (n < 6 || (n < 80 && q_ram.size() + q_per.size() + q_irq.size() != 0))
        begin
            @(posedge pclk);
            n++;
        end
        check("left over", 33'h0, 33'(q_ram.size() + q_per.size() + q_irq.size()));
    endtask : settle
    task automatic kick(input int line);
        req_lines[line] <= 1'b1;
        @(posedge pclk);
        req_lines[line] <= 1'b0;
        settle();
    endtask : kick
    always @(posedge pclk)
    begin : mon
        logic [32:0] e;
        if (psel && penable && !pwrite)
        begin
            e = q_rd.size() != 0 ? q_rd.pop_front() : 'x;
            check("apb read", e, {pslverr, prdata});
        end
        if (ram_wr !== 1'b0)
        begin
            e = q_ram.size() != 0 ? q_ram.pop_front() : 'x;
            check("ram write", e, {!byte_xfer, ram_addr, ram_wdata});
        end
        if (periph_wr !== 1'b0)
        begin
            e = q_per.size() != 0 ? q_per.pop_front() : 'x;
            check("periph write", e, {!byte_xfer, periph_addr, periph_wdata});
        end
        if (dma_irq !== 8'h00)
        begin
            e = q_irq.size() != 0 ? {25'h0, q_irq.pop_front()} : 'x;
            check("irq", e, {25'h0, dma_irq});
            check("irq channel", e, {25'h0, 8'(8'h01 << xfer_channel)});
        end
    end
    always @(posedge pclk)
    begin
        cyc++;
        // the whole sequence needs about 350 cycles
        if (cyc == 20000)
        begin
            err_total++;
            stop_test();
        end
    end
    initial
    begin
        logic [2:0] ca, cb;
        logic [6:0] sel;
        logic [15:0] a, b, p, p2, m;
        logic [31:0] v;
        void'($urandom(11));
        ca = 3'($urandom % 7);
        cb = 3'(ca + 1 + $urandom % (7 - ca));
        sel = 7'($urandom);
        a = 16'($urandom) & 16'hFE00;
        b = a ^ 16'h4000;
        p = 16'($urandom);
        p2 = 16'($urandom);
        repeat (6) @(posedge pclk);
        presetn <= 1'b1;
        @(posedge pclk);
        for (int r = 0; r < 6; r++) rd(ra(cb, 5'(r * 4)), 33'h0);
        rd(REG_CHAN_STAT, 33'h0F00);
        $display("test reset values done");
        for (int r = 0; r < 6; r++)
        begin
            v = $urandom;
            // on and force stay clear here so no transfer starts behind the test's back
            if (r < 2) v[15] = 1'b0;
            m = r == 0 ? 16'h7833 : r == 1 ? REQ_SEL_MASK : r == 5 ? LEN_MASK : 16'hFFFF;
            apb(1'b1, ra(ca, 5'(r * 4)), v);
            rd(ra(ca, 5'(r * 4)), {17'h0, v[15:0] & m});
        end
        apb(1'b1, ra(ca, 5'h18), v);
        rd(ra(ca, 5'h18), {1'b1, 32'h0});
        $display("test register access done");
        cfg(ca, 16'h8000, sel, a, 0, p, 3);
        cfg(cb, 16'h8000, sel, a + 16'h0100, 0, p2, 3);
        for (int i = 0; i < 5; i++)
        begin
            q_ram.push_back({1'b1, a + 16'(2 * (i % 4)), p ^ 16'h5AA5});
            q_ram.push_back({1'b1, a + 16'h0100 + 16'(2 * (i % 4)), p2 ^ 16'h5AA5});
            if (i == 3) q_irq.push_back(8'h01 << ca);
            if (i == 3) q_irq.push_back(8'h01 << cb);
            kick(int'(sel));
        end
        apb(1'b1, ra(ca, REG_CTRL), 32'h0);
        apb(1'b1, ra(cb, REG_CTRL), 32'h0);
        kick(int'(sel));
        $display("test continuous priority done");
        cfg(ca, 16'hC001, sel, a, 0, p, 1);
        for (int i = 0; i < 3; i++)
        begin
            if (i < 2) q_ram.push_back({1'b0, a + 16'(i), p ^ 16'h5AA5});
            if (i == 1) q_irq.push_back(8'h01 << ca);
            kick(int'(sel));
        end
        rd(ra(ca, REG_CTRL), 33'h4001);
        $display("test byte one-shot done");
        cfg(ca, 16'h9812, sel, a, b, p, 1);
        for (int i = 0; i < 5; i++)
        begin
            q_ram.push_back({1'b1, (i / 2) % 2 ? b : a, p ^ 16'h5AA5});
            q_per.push_back({1'b1, p, 16'h0000});
            if (i % 2 == 0) q_irq.push_back(8'h01 << ca);
            kick(int'(sel));
            if (i == 1) rd(REG_CHAN_STAT, {22'h0, ca, 8'h01 << ca});
        end
        apb(1'b1, ra(ca, REG_CTRL), 32'h0);
        $display("test ping-pong null write done");
        ind_off <= 16'($urandom) & 16'h00FE;
        cfg(ca, 16'hA023, sel, a, b, p, 0);
        for (int i = 0; i < 2; i++)
        begin
            q_per.push_back({1'b1, p, ((i == 0 ? a : b) | ind_off) ^ 16'hC33C});
            q_irq.push_back(8'h01 << ca);
            apb(1'b1, ra(ca, REG_REQ), {16'h0, 16'h8000 | 16'(sel)});
            settle();
            rd(ra(ca, REG_REQ), {26'h0, sel});
        end
        rd(ra(ca, REG_CTRL), 33'h2023);
        apb(1'b1, ra(cb, REG_REQ), 32'h0000_8000);
        apb(1'b1, ra(cb, REG_REQ), 32'h0000_0000);
        rd(ra(cb, REG_REQ), 33'h8000);
        $display("test forced indirect done");
        stop_test();
    end
endmodule : dmacc_top_bench
`default_nettype wire
